// [verilog/fir_pkg.sv]
// Constants, types and decode helpers of the fault interrupt enable bank.
`default_nettype none
package fir_pkg;
	typedef logic [7:0] fir_addr_t;
	typedef logic [15:0] fir_word_t;
	typedef logic [7:0] fir_on_t;

	localparam fir_addr_t FIR_SUP_EN = 8'h08;
	localparam fir_addr_t FIR_BST_EN = 8'h0a;
	localparam fir_addr_t FIR_LED_EN = 8'h0c;
	localparam fir_addr_t FIR_SUP_STAT = 8'h0e;
	localparam fir_addr_t FIR_BST_STAT = 8'h10;
	localparam fir_addr_t FIR_LED_STAT = 8'h12;

	localparam fir_word_t FIR_SUP_RST = 16'h2aaa;
	localparam fir_word_t FIR_BST_RST = 16'ha028;
	localparam fir_word_t FIR_LED_RST = 16'h00aa;

	localparam fir_on_t FIR_SUP_FIELDS = 8'h7f;
	localparam fir_on_t FIR_SUP_RST_ON = 8'h7f;
	localparam fir_on_t FIR_BST_FIELDS = 8'hfe;
	localparam fir_on_t FIR_BST_RST_ON = 8'hc6;
	localparam fir_on_t FIR_LED_FIELDS = 8'h0f;
	localparam fir_on_t FIR_LED_RST_ON = 8'h0f;

	localparam logic [1:0] FIR_RD_ON = 2'h2;
	localparam logic [1:0] FIR_RD_OFF = 2'h0;
	localparam logic [1:0] FIR_WR_OFF = 2'h1;
	localparam logic [1:0] FIR_WR_ON = 2'h3;

	localparam int FIR_NFIELD = 8;
	localparam int FIR_NREG = 3;
	localparam int FIR_NSLOT = 24;

	function automatic logic fir_hit(input fir_addr_t a, input fir_addr_t off);
		return a == off;
	endfunction

	function automatic fir_word_t fir_en_rd(input fir_on_t on);
		fir_word_t r;
		r = 16'h0000;
		for (int i = 0; i < FIR_NFIELD; i++) begin
			r[2*i+:2] = on[i] ? FIR_RD_ON : FIR_RD_OFF;
		end
		return r;
	endfunction

	function automatic fir_word_t fir_stat_rd(input fir_on_t st);
		fir_word_t r;
		r = 16'h0000;
		for (int i = 0; i < FIR_NFIELD; i++) begin
			r[2*i+1] = st[i];
		end
		return r;
	endfunction
endpackage
`default_nettype wire

// [verilog/fir_flt_if.sv]
// Carrier between the register top and the fault latch.
`timescale 1ns/1ps
`default_nettype none
interface fir_flt_if;
	logic [23:0] raw;
	logic [23:0] on;
	logic [23:0] filt;
	logic [23:0] stat;
	logic clr_wr;
	logic [1:0] clr_reg;
	logic [15:0] clr_data;
	modport ctl (output raw, on, clr_wr, clr_reg, clr_data, input filt, stat);
	modport lat (input raw, on, clr_wr, clr_reg, clr_data, output filt, stat);
endinterface
`default_nettype wire

// [verilog/fir_en_bank.sv]
// One register of two-bit interrupt enable fields.
`timescale 1ns/1ps
`default_nettype none
module fir_en_bank import fir_pkg::*; #(
	parameter fir_on_t FIELDS = 8'hff,
	parameter fir_on_t RST_ON = 8'h00
) (
	// Clock and reset.
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	// Register write.
	input wire logic wr_in,
	input wire logic [15:0] wdata_in,
	// Field state.
	output logic [7:0] on_out,
	output logic [15:0] rdata_out
);
	fir_on_t on_r;

	genvar k;
	generate
		for (k = 0; k < FIR_NFIELD; k++) begin : g_field
			always_ff @(posedge mclk_in or posedge sys_rst_in) begin
				if (sys_rst_in) begin
					on_r[k] <= RST_ON[k] & FIELDS[k];
				end else if (wr_in && FIELDS[k]) begin
					case (wdata_in[2*k+:2])
						FIR_WR_OFF: on_r[k] <= 1'b0;
						FIR_WR_ON: on_r[k] <= 1'b1;
						default: on_r[k] <= on_r[k];
					endcase
				end
			end
		end
	endgenerate

	assign on_out = on_r & FIELDS;
	assign rdata_out = fir_en_rd(on_r & FIELDS);
endmodule // fir_en_bank
`default_nettype wire

// [verilog/fir_flt_latch.sv]
// Fault input synchroniser and sticky fault status bits.
`timescale 1ns/1ps
`default_nettype none
module fir_flt_latch import fir_pkg::*; (
	// Clock and reset.
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	// Link to the register top.
	fir_flt_if.lat flt
);
	logic [23:0] s1_r;
	logic [23:0] s2_r;
	logic [23:0] s3_r;
	logic [23:0] filt_r;
	logic [23:0] stat_r;
	logic [23:0] clr;

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			s1_r <= 24'h000000;
			s2_r <= 24'h000000;
			s3_r <= 24'h000000;
		end else begin
			s1_r <= flt.raw;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			filt_r <= 24'h000000;
		end else begin
			filt_r <= (s2_r & ~(s2_r ^ s3_r)) | (filt_r & (s2_r ^ s3_r));
		end
	end

	genvar r, k;
	generate
		for (r = 0; r < FIR_NREG; r++) begin : g_reg
			for (k = 0; k < FIR_NFIELD; k++) begin : g_bit
				assign clr[r*FIR_NFIELD+k] = flt.clr_wr
					&& (flt.clr_reg == 2'(r))
					&& flt.clr_data[2*k+1] && flt.clr_data[2*k];
			end
		end
	endgenerate

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			stat_r <= 24'h000000;
		end else begin
			stat_r <= filt_r | (stat_r & ~clr);
		end
	end

	assign flt.filt = filt_r;
	assign flt.stat = stat_r;
endmodule // fir_flt_latch
`default_nettype wire

// [verilog/fir_top.sv]
// Fault interrupt enable registers, fault latches and interrupt output.
`timescale 1ns/1ps
`default_nettype none
module fir_top import fir_pkg::*; (
	// Clock and reset.
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	// Register port.
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	output logic [15:0] reg_rdata_out,
	output logic reg_rvalid_out,
	// Fault detector levels.
	input wire logic [6:0] supply_fault_in,
	input wire logic [5:0] boost_fault_in,
	input wire logic [3:0] led_fault_in,
	// Interrupt.
	output logic irq_out
);

	// ----------------------------------------------------------------
	// Declarations.
	// ----------------------------------------------------------------

	fir_flt_if flt ();

	fir_on_t sup_on;
	fir_on_t bst_on;
	fir_on_t led_on;
	fir_word_t sup_rd;
	fir_word_t bst_rd;
	fir_word_t led_rd;
	fir_word_t rdata_nxt;
	fir_word_t rdata_r;
	logic rvalid_r;
	logic irq_r;
	logic sup_wr;
	logic bst_wr;
	logic led_wr;

	// ----------------------------------------------------------------
	// Address decode.
	// ----------------------------------------------------------------

	assign sup_wr = reg_wr_in && fir_hit(reg_addr_in, FIR_SUP_EN);

	assign bst_wr = reg_wr_in && fir_hit(reg_addr_in, FIR_BST_EN);

	assign led_wr = reg_wr_in && fir_hit(reg_addr_in, FIR_LED_EN);

	// ----------------------------------------------------------------
	// Enable registers.
	// ----------------------------------------------------------------

	fir_en_bank #(
		.FIELDS(FIR_SUP_FIELDS),
		.RST_ON(FIR_SUP_RST_ON)
	) u_sup (
		.mclk_in(mclk_in),
		.sys_rst_in(sys_rst_in),
		.wr_in(sup_wr),
		.wdata_in(reg_wdata_in),
		.on_out(sup_on),
		.rdata_out(sup_rd)
	);

	fir_en_bank #(
		.FIELDS(FIR_BST_FIELDS),
		.RST_ON(FIR_BST_RST_ON)
	) u_bst (
		.mclk_in(mclk_in),
		.sys_rst_in(sys_rst_in),
		.wr_in(bst_wr),
		.wdata_in(reg_wdata_in),
		.on_out(bst_on),
		.rdata_out(bst_rd)
	);

	fir_en_bank #(
		.FIELDS(FIR_LED_FIELDS),
		.RST_ON(FIR_LED_RST_ON)
	) u_led (
		.mclk_in(mclk_in),
		.sys_rst_in(sys_rst_in),
		.wr_in(led_wr),
		.wdata_in(reg_wdata_in),
		.on_out(led_on),
		.rdata_out(led_rd)
	);

	// ----------------------------------------------------------------
	// Fault latches.
	// ----------------------------------------------------------------

	assign flt.raw = {4'h0, led_fault_in, boost_fault_in, 2'h0,
		1'b0, supply_fault_in};
	assign flt.on = {led_on, bst_on, sup_on};
	assign flt.clr_wr = reg_wr_in && (fir_hit(reg_addr_in, FIR_SUP_STAT)
		|| fir_hit(reg_addr_in, FIR_BST_STAT)
		|| fir_hit(reg_addr_in, FIR_LED_STAT));
	assign flt.clr_reg = fir_hit(reg_addr_in, FIR_BST_STAT) ? 2'h1 :
		fir_hit(reg_addr_in, FIR_LED_STAT) ? 2'h2 : 2'h0;
	assign flt.clr_data = reg_wdata_in;

	fir_flt_latch u_latch (
		.mclk_in(mclk_in),
		.sys_rst_in(sys_rst_in),
		.flt(flt.lat)
	);

	// ----------------------------------------------------------------
	// Read path.
	// ----------------------------------------------------------------

	always_comb begin
		case (reg_addr_in)
			FIR_SUP_EN: rdata_nxt = sup_rd;
			FIR_BST_EN: rdata_nxt = bst_rd;
			FIR_LED_EN: rdata_nxt = led_rd;
			FIR_SUP_STAT: rdata_nxt = fir_stat_rd(flt.stat[7:0]);
			FIR_BST_STAT: rdata_nxt = fir_stat_rd(flt.stat[15:8]);
			FIR_LED_STAT: rdata_nxt = fir_stat_rd(flt.stat[23:16]);
			default: rdata_nxt = 16'h0000;
		endcase
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rdata_r <= 16'h0000;
		end else if (reg_rd_in) begin
			rdata_r <= rdata_nxt;
		end
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rvalid_r <= 1'b0;
		end else begin
			rvalid_r <= reg_rd_in;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt output.
	// ----------------------------------------------------------------

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(flt.stat & flt.on);
		end
	end

	assign reg_rdata_out = rdata_r;
	assign reg_rvalid_out = rvalid_r;
	assign irq_out = irq_r;

	// ----------------------------------------------------------------
	// Checks.
	// ----------------------------------------------------------------

	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (sys_rst_in);

	logic first_r;

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			first_r <= 1'b1;
		end else begin
			first_r <= 1'b0;
		end
	end

	sequence seq_rd_sup;
		reg_rd_in && reg_addr_in == FIR_SUP_EN;
	endsequence

	sequence seq_rd_bst;
		reg_rd_in && reg_addr_in == FIR_BST_EN;
	endsequence

	sequence seq_wr_cp;
		sup_wr && reg_wdata_in == 16'h0c00 ##1 seq_rd_sup;
	endsequence

	sequence seq_wr_uv_off;
		sup_wr && reg_wdata_in == 16'h0001 ##1 seq_rd_sup;
	endsequence

	sequence seq_wr_fset_on;
		bst_wr && reg_wdata_in == 16'h00c0 ##1 seq_rd_bst;
	endsequence

	sequence seq_uv_fault;
		(supply_fault_in[0] && sup_on[0]) [*4];
	endsequence

	AST_RD_CODE: assert property (
		seq_rd_sup |=> ((reg_rdata_out & 16'h5555) == 16'h0000)
	) else $error("enable readback has an odd code bit");

	AST_WR_OFF: assert property (
		bst_wr && reg_wdata_in[15:14] == FIR_WR_OFF |=> !bst_on[7]
	) else $error("write of 1h did not disable");

	AST_WR_ON: assert property (
		led_wr && reg_wdata_in[1:0] == FIR_WR_ON |=> led_on[0]
	) else $error("write of 3h did not enable");

	AST_WR_HOLD: assert property (
		sup_wr && !reg_wdata_in[12] |=> $stable(sup_on[6])
	) else $error("write of 0h or 2h changed a field");

	AST_CP_POS: assert property (
		seq_wr_cp |=> reg_rdata_out[11:10] == FIR_RD_ON
	) else $error("charge pump field misplaced");

	AST_UV_POS: assert property (
		seq_wr_uv_off |=> reg_rdata_out[1:0] == FIR_RD_OFF
	) else $error("input under-voltage field misplaced");

	AST_SUP_RST: assert property (
		first_r |-> sup_rd == FIR_SUP_RST
	) else $error("supply enable reset value wrong");

	AST_BST_RST: assert property (
		first_r |-> bst_rd == FIR_BST_RST
	) else $error("boost enable reset value wrong");

	AST_LED_RST: assert property (
		first_r |-> led_rd == FIR_LED_RST
	) else $error("led enable reset value wrong");

	AST_FSET_POS: assert property (
		seq_wr_fset_on |=> reg_rdata_out[7:6] == FIR_RD_ON
	) else $error("frequency resistor field misplaced");

	AST_BST_RSV: assert property (
		seq_rd_bst |=> reg_rdata_out[1:0] == 2'h0
	) else $error("boost reserved bits not zero");

	AST_SUP_RSV: assert property (
		seq_rd_sup |=> reg_rdata_out[15:14] == 2'h0
	) else $error("supply reserved bits not zero");

	AST_CLR: assert property (
		flt.clr_wr && flt.clr_reg == 2'h0 && reg_wdata_in[1:0] == 2'h3
		&& !flt.filt[0] |=> !flt.stat[0]
	) else $error("status not cleared by write of both bits");

	AST_STICKY: assert property (
		flt.stat[0] && !(flt.clr_wr && flt.clr_reg == 2'h0
		&& reg_wdata_in[1:0] == 2'h3) |=> flt.stat[0]
	) else $error("status dropped without a clear");

	AST_IRQ_RISE: assert property (
		seq_uv_fault |-> ##[1:4] irq_out
	) else $error("enabled fault did not raise the interrupt");

	AST_IRQ_GATE: assert property (
		irq_out |-> $past(|(flt.stat & flt.on))
	) else $error("interrupt raised without an enabled fault");

endmodule // fir_top
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench of the fault interrupt enable bank.
`timescale 1ns/1ps
`default_nettype none
module tb_top import fir_pkg::*;;
	// ------------------------------------------------------------
	// Stimulus and design.
	// ------------------------------------------------------------
	logic mclk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	fir_addr_t reg_addr_in = 8'h00;
	fir_word_t reg_wdata_in = 16'h0000;
	fir_word_t reg_rdata_out;
	logic reg_rvalid_out;
	logic irq_out;
	logic [6:0] sup_flt = 7'h00;
	logic [5:0] bst_flt = 6'h00;
	logic [3:0] led_flt = 4'h0;
	int n_fail = 0;
	int checked = 0;
	int cyc = 0;

	fir_top DUT (
		.mclk_in(mclk_in),
		.sys_rst_in(sys_rst_in),
		.reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in),
		.reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in),
		.reg_rdata_out(reg_rdata_out),
		.reg_rvalid_out(reg_rvalid_out),
		.supply_fault_in(sup_flt),
		.boost_fault_in(bst_flt),
		.led_fault_in(led_flt),
		.irq_out(irq_out)
	);

	initial begin
		forever #12.5 mclk_in = ~mclk_in;
	end

	always @(posedge mclk_in) begin
		cyc++;
		if (cyc == 6000) begin
			n_fail++;
			wrap_up();
		end
	end

	// ------------------------------------------------------------
	// Shared tasks.
	// ------------------------------------------------------------
	task automatic wrap_up();
		if (n_fail == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input fir_word_t e, input fir_word_t g);
		checked++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			n_fail++;
		end
	endtask

	task automatic wr(input fir_addr_t a, input fir_word_t d);
		@(posedge mclk_in);
		#2;
		reg_wr_in = 1'b1;
		reg_addr_in = a;
		reg_wdata_in = d;
		@(posedge mclk_in);
		#2;
		reg_wr_in = 1'b0;
	endtask

	task automatic rc(input fir_addr_t a, input fir_word_t e, input string nm);
		@(posedge mclk_in);
		#2;
		reg_rd_in = 1'b1;
		reg_addr_in = a;
		@(posedge mclk_in);
		#2;
		reg_rd_in = 1'b0;
		chk("read valid", 16'h0001, {15'h0000, reg_rvalid_out});
		chk(nm, e, reg_rdata_out);
	endtask

	task automatic wr_rd(input fir_addr_t a, input fir_word_t d,
		input fir_word_t e, input string nm);
		@(posedge mclk_in);
		#2;
		reg_wr_in = 1'b1;
		reg_addr_in = a;
		reg_wdata_in = d;
		@(posedge mclk_in);
		#2;
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b1;
		@(posedge mclk_in);
		#2;
		reg_rd_in = 1'b0;
		chk(nm, e, reg_rdata_out);
	endtask

	task automatic drive_flt(input int g, input int k, input logic v);
		case (g)
			0: sup_flt[k] = v;
			1: bst_flt[k] = v;
			default: led_flt[k] = v;
		endcase
	endtask

	task automatic wait_irq(input logic v, input string nm);
		int n;
		n = 0;
		while (irq_out !== v && n < 10) begin
			@(posedge mclk_in);
			#2;
			n++;
		end
		chk(nm, {15'h0000, v}, {15'h0000, irq_out});
	endtask

	task automatic flt(input int g, input int k, input fir_addr_t sa);
		fir_word_t e;
		e = 16'h0002 << (2 * ((g == 1) ? k + 2 : k));
		@(posedge mclk_in);
		#2;
		drive_flt(g, k, 1'b1);
		wait_irq(1'b1, "irq raised");
		drive_flt(g, k, 1'b0);
		repeat (6) @(posedge mclk_in);
		rc(sa, e, "status sticky");
		wr(sa, e | (e >> 1));
		@(posedge mclk_in);
		#2;
		chk("irq cleared", 16'h0000, {15'h0000, irq_out});
		rc(sa, 16'h0000, "status cleared");
	endtask

	// ------------------------------------------------------------
	// Register rows: write flag, offset, write data, read value.
	// ------------------------------------------------------------
	localparam logic [40:0] ROWS [22] = '{
		{1'b0, 8'h08, 16'h0000, 16'h2aaa},
		{1'b0, 8'h0a, 16'h0000, 16'ha028},
		{1'b0, 8'h0c, 16'h0000, 16'h00aa},
		{1'b1, 8'h20, 16'hffff, 16'h0000},
		{1'b1, 8'h08, 16'h5555, 16'h0000},
		{1'b1, 8'h08, 16'hffff, 16'h2aaa},
		{1'b1, 8'h08, 16'h0001, 16'h2aa8},
		{1'b1, 8'h08, 16'h0004, 16'h2aa0},
		{1'b1, 8'h08, 16'h0010, 16'h2a80},
		{1'b1, 8'h08, 16'h0040, 16'h2a00},
		{1'b1, 8'h08, 16'h0100, 16'h2800},
		{1'b1, 8'h08, 16'h0400, 16'h2000},
		{1'b1, 8'h08, 16'h1000, 16'h0000},
		{1'b1, 8'h08, 16'haaaa, 16'h0000},
		{1'b1, 8'h08, 16'h3003, 16'h2002},
		{1'b1, 8'h0a, 16'h0000, 16'ha028},
		{1'b1, 8'h0a, 16'hffff, 16'haaa8},
		{1'b1, 8'h0a, 16'h5555, 16'h0000},
		{1'b1, 8'h0a, 16'hc003, 16'h8000},
		{1'b1, 8'h0a, 16'h3c30, 16'ha820},
		{1'b1, 8'h0c, 16'h5555, 16'h0000},
		{1'b1, 8'h0c, 16'hffff, 16'h00aa}
	};

	// ------------------------------------------------------------
	// Main sequence.
	// ------------------------------------------------------------
	initial begin
		repeat (5) @(posedge mclk_in);
		#2;
		sys_rst_in = 1'b0;
		for (int i = 0; i < 22; i++) begin
			if (ROWS[i][40]) begin
				wr(ROWS[i][39:32], ROWS[i][31:16]);
			end
			rc(ROWS[i][39:32], ROWS[i][15:0], "row read");
		end
		wr_rd(FIR_SUP_EN, 16'h0c00, 16'h2802, "pump after write");
		wr_rd(FIR_SUP_EN, 16'h0001, 16'h2800, "uv after write");
		wr_rd(FIR_BST_EN, 16'h00c0, 16'ha8a0, "freq after write");
		wr(FIR_SUP_EN, 16'hffff);
		wr(FIR_BST_EN, 16'hffff);
		for (int k = 0; k < 7; k++) begin
			flt(0, k, FIR_SUP_STAT);
		end
		for (int k = 0; k < 6; k++) begin
			flt(1, k, FIR_BST_STAT);
		end
		for (int k = 0; k < 4; k++) begin
			flt(2, k, FIR_LED_STAT);
		end
		wr(FIR_SUP_EN, 16'h0001);
		@(posedge mclk_in);
		#2;
		sup_flt[0] = 1'b1;
		repeat (8) @(posedge mclk_in);
		#2;
		chk("irq masked", 16'h0000, {15'h0000, irq_out});
		rc(FIR_SUP_STAT, 16'h0002, "masked status");
		wr(FIR_SUP_STAT, 16'h0003);
		rc(FIR_SUP_STAT, 16'h0002, "set wins");
		wr(FIR_SUP_EN, 16'h0003);
		wait_irq(1'b1, "irq unmasked");
		sup_flt[0] = 1'b0;
		repeat (6) @(posedge mclk_in);
		wr(FIR_SUP_STAT, 16'h0002);
		rc(FIR_SUP_STAT, 16'h0002, "half clear");
		wr(FIR_SUP_STAT, 16'h0003);
		@(posedge mclk_in);
		#2;
		chk("irq after clear", 16'h0000, {15'h0000, irq_out});
		@(posedge mclk_in);
		#2;
		reg_wr_in = 1'b1;
		reg_rd_in = 1'b1;
		reg_addr_in = FIR_SUP_EN;
		reg_wdata_in = 16'h5555;
		@(posedge mclk_in);
		#2;
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		chk("read beside write", 16'h2aaa, reg_rdata_out);
		rc(FIR_SUP_EN, 16'h0000, "after same cycle");
		wr(FIR_BST_EN, 16'h5555);
		@(posedge mclk_in);
		#2;
		sys_rst_in = 1'b1;
		repeat (2) @(posedge mclk_in);
		#2;
		sys_rst_in = 1'b0;
		rc(FIR_BST_EN, 16'ha028, "boost after reset");
		rc(FIR_SUP_EN, 16'h2aaa, "supply after reset");
		wrap_up();
	end
endmodule // tb_top
`default_nettype wire
